// ===== logic/adcsc_ctrl.sv
// converter control and readout: calibration sequencer, filter sync/settle
// timing, word-ready and data-valid flags and the parallel read port
// assumes every input except SYS_RST_IN and FILTER_SYNC_IN is synchronous
`timescale 1ns/100ps
`default_nettype none

module adcsc_ctrl #(
  parameter int SETTLE_CYCLES = adcsc_pkg::SETTLE_CYCLES,
  parameter int CONV_CYCLES = adcsc_pkg::CONV_CYCLES,
  parameter int CAL_PHASE_CYCLES = adcsc_pkg::CAL_PHASE_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic PARALLEL_SEL_IN,
  input wire logic CAL_START_IN,
  input wire logic FILTER_SYNC_IN,
  input wire logic CHIP_SELECT_N_IN,
  input wire logic READ_STROBE_N_IN,
  input wire logic [adcsc_pkg::WORD_WIDTH-1:0] RAW_WORD_IN,
  input wire logic [adcsc_pkg::WORD_WIDTH-1:0] CAL_OFFSET_IN,
  input wire logic [adcsc_pkg::WORD_WIDTH-1:0] CAL_GAIN_IN,
  output logic [adcsc_pkg::WORD_WIDTH-1:0] PARALLEL_DATA_BUS_OUT,
  output logic PARALLEL_DATA_BUS_OE_OUT,
  output logic WORD_READY_N_OUT,
  output logic SERIAL_DATA_VALID_OUT,
  output logic MOD_DISCHARGE_OUT,
  output logic CAL_BUSY_OUT,
  output logic CALIBRATED_OUT,
  output logic [adcsc_pkg::WORD_WIDTH-1:0] CAL_OFFSET_OUT,
  output logic [adcsc_pkg::WORD_WIDTH-1:0] CAL_GAIN_OUT
);

  localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
  localparam int PH_W = $clog2(CONV_CYCLES);
  localparam int CAL_W = $clog2(CAL_PHASE_CYCLES);
  localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(SETTLE_CYCLES);
  localparam logic [PH_W-1:0] PHASE_ZERO = PH_W'(0);
  localparam logic [PH_W-1:0] PHASE_PULSE = PH_W'(CONV_CYCLES - adcsc_pkg::READY_HIGH_CYCLES);
  localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_PHASE_CYCLES - 1);

  // the phase counter wraps naturally, so the convolution length must be 2**n
  if (CONV_CYCLES < 4 || (1 << PH_W) != CONV_CYCLES) begin : g_bad_conv
    $error("CONV_CYCLES must be a power of two, at least 4");
  end
  if (SETTLE_CYCLES < CONV_CYCLES || CAL_PHASE_CYCLES < 2) begin : g_bad_time
    $error("SETTLE_CYCLES or CAL_PHASE_CYCLES out of range");
  end
  // the calibration deadline in a_cal_run must stay within a checkable span
  if (CAL_PHASE_CYCLES > 499) begin : g_bad_cal
    $error("CAL_PHASE_CYCLES above 499 not supported");
  end

  // every register below runs on CLK_IN alone; only reset and sync act between edges [R01]
  // sync and reset both restart the filter; level-held so the counter stays at zero
  logic filt_rst;
  assign filt_rst = SYS_RST_IN | FILTER_SYNC_IN; // [R07] [R12] [R21]

  logic [SETTLE_W-1:0] settle_q;
  logic settled_d;
  logic serial_data_valid_q;
  logic [PH_W-1:0] phase_q;
  logic word_ready_n_q;
  logic sdv_q;
  logic [adcsc_pkg::WORD_WIDTH-1:0] word_q;
  logic rd_act_q;
  logic rd_now;
  logic rd_done;
  logic upd;
  logic mod_dis_q;
  adcsc_pkg::adcsc_cal_type cal_state_q;
  logic [CAL_W-1:0] cal_cnt_q;
  logic calibrated_q;
  logic [adcsc_pkg::WORD_WIDTH-1:0] cal_off_q;
  logic [adcsc_pkg::WORD_WIDTH-1:0] cal_gain_q;

  // read port: both strobes taken as levels at the clock edge only
  assign rd_now = PARALLEL_SEL_IN & ~CHIP_SELECT_N_IN & ~READ_STROBE_N_IN; // [R08] [R18] [R02]
  assign rd_done = rd_act_q & ~rd_now; // [R19]
  assign settled_d = (settle_q == SETTLE_END);
  assign upd = serial_data_valid_q & (phase_q == PHASE_ZERO);

  // modulator integrator discharge: held through reset, dropped at first edge
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mod_dis_q <= 1'h1; // [R06] [R05]
    end else begin
      mod_dis_q <= 1'h0;
    end
  end

  // settle counter since release; saturates once the filter has settled
  always_ff @(posedge CLK_IN or posedge filt_rst) begin
    if (filt_rst) begin
      settle_q <= '0; // [R15]
    end else if (!settled_d) begin
      settle_q <= settle_q + SETTLE_W'(1);
    end
  end

  // filter sequencer counter, zeroed and held by sync or reset
  always_ff @(posedge CLK_IN or posedge filt_rst) begin
    if (filt_rst) begin
      phase_q <= PHASE_ZERO; // [R13] [R21]
    end else begin
      phase_q <= phase_q + PH_W'(1);
    end
  end

  // settled flag; set one edge after the counter saturates, sticky until sync or reset
  always_ff @(posedge CLK_IN or posedge filt_rst) begin
    if (filt_rst) begin
      serial_data_valid_q <= 1'h0;
    end else if (settled_d) begin
      serial_data_valid_q <= 1'h1; // [R16]
    end
  end

  // serial data valid pin only carries the flag in serial mode
  always_ff @(posedge CLK_IN or posedge filt_rst) begin
    if (filt_rst) begin
      sdv_q <= 1'h0; // [R14]
    end else begin
      sdv_q <= settled_d & ~PARALLEL_SEL_IN; // [R16] [R02]
    end
  end

  // output word register; updates once per convolution after settling
  always_ff @(posedge CLK_IN or posedge filt_rst) begin
    if (filt_rst) begin
      word_q <= adcsc_pkg::WORD_RST;
    end else if (upd) begin
      word_q <= RAW_WORD_IN; // [R17]
    end
  end

  // word ready: update wins over read completion so no new word is missed
  always_ff @(posedge CLK_IN or posedge filt_rst) begin
    if (filt_rst) begin
      word_ready_n_q <= 1'h1; // [R15]
    end else if (!PARALLEL_SEL_IN) begin
      word_ready_n_q <= 1'h1; // [R02]
    end else if (upd) begin
      word_ready_n_q <= 1'h0; // [R17] [R19]
    end else if (rd_done) begin
      word_ready_n_q <= 1'h1; // [R19]
    end else if (serial_data_valid_q && phase_q == PHASE_PULSE) begin
      word_ready_n_q <= 1'h1; // [R20]
    end
  end

  // bus enable: follows the sampled strobes; chip select high floats it
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rd_act_q <= 1'h0;
    end else begin
      rd_act_q <= rd_now; // [R09] [R10]
    end
  end

  // calibration sequencer: offset phase, then gain phase, then stored values
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cal_state_q <= adcsc_pkg::CAL_IDLE;
      cal_cnt_q <= '0;
    end else begin
      case (cal_state_q)
        adcsc_pkg::CAL_IDLE: begin
          cal_cnt_q <= '0;
          if (CAL_START_IN) begin
            cal_state_q <= adcsc_pkg::CAL_OFFSET; // [R03]
          end
        end
        adcsc_pkg::CAL_OFFSET: begin
          cal_cnt_q <= cal_cnt_q + CAL_W'(1);
          if (cal_cnt_q == CAL_LAST) begin
            cal_cnt_q <= '0; // explicit restart: the count need not wrap unless 2**n
            cal_state_q <= adcsc_pkg::CAL_GAIN;
          end
        end
        adcsc_pkg::CAL_GAIN: begin
          cal_cnt_q <= cal_cnt_q + CAL_W'(1);
          if (cal_cnt_q == CAL_LAST) begin
            cal_cnt_q <= '0;
            cal_state_q <= adcsc_pkg::CAL_IDLE;
          end
        end
        default: begin
          cal_state_q <= adcsc_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  // stored calibration values; only reset returns to the uncalibrated state
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cal_off_q <= adcsc_pkg::WORD_RST; // [R04] [R05]
      cal_gain_q <= adcsc_pkg::WORD_RST;
      calibrated_q <= 1'h0;
    end else if (cal_cnt_q == CAL_LAST) begin
      if (cal_state_q == adcsc_pkg::CAL_OFFSET) begin
        cal_off_q <= CAL_OFFSET_IN; // [R03]
      end
      if (cal_state_q == adcsc_pkg::CAL_GAIN) begin
        cal_gain_q <= CAL_GAIN_IN; // [R03]
        calibrated_q <= 1'h1;
      end
    end
  end

  // cal status outputs registered so every output leaves a flip-flop
  logic cal_busy_q;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cal_busy_q <= 1'h0;
    end else begin
      cal_busy_q <= (cal_state_q != adcsc_pkg::CAL_IDLE) | CAL_START_IN;
    end
  end

  assign PARALLEL_DATA_BUS_OUT = word_q;
  assign PARALLEL_DATA_BUS_OE_OUT = rd_act_q;
  assign WORD_READY_N_OUT = word_ready_n_q;
  assign SERIAL_DATA_VALID_OUT = sdv_q;
  assign MOD_DISCHARGE_OUT = mod_dis_q;
  assign CAL_BUSY_OUT = cal_busy_q;
  assign CALIBRATED_OUT = calibrated_q;
  assign CAL_OFFSET_OUT = cal_off_q;
  assign CAL_GAIN_OUT = cal_gain_q;

  // checking helper: edges since the filter left reset, saturating
  localparam int CAL_MAX = 2 * CAL_PHASE_CYCLES + 2;
  logic [SETTLE_W:0] since_q;
  always_ff @(posedge CLK_IN or posedge filt_rst) begin
    if (filt_rst) begin
      since_q <= '0;
    end else if (!since_q[SETTLE_W]) begin
      since_q <= since_q + (SETTLE_W+1)'(1);
    end
  end

  // a select sampled high lets go of the bus on the next edge
  a_bus_float: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // [R10]
    CHIP_SELECT_N_IN |=> !PARALLEL_DATA_BUS_OE_OUT)
    else $error("bus driven after chip select sampled high");

  // a read strobe sampled high lets go of the bus as well
  a_read_float: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // [R18]
    READ_STROBE_N_IN |=> !PARALLEL_DATA_BUS_OE_OUT)
    else $error("bus driven after read strobe sampled high");

  // both strobes sampled low in parallel mode enable the bus one edge later
  a_bus_drive: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // [R09]
    (PARALLEL_SEL_IN && !CHIP_SELECT_N_IN && !READ_STROBE_N_IN) |=> PARALLEL_DATA_BUS_OE_OUT)
    else $error("bus not driven after read sampled");

  // serial mode keeps the parallel handshake pins quiet
  a_serial_quiet: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R02]
    !PARALLEL_SEL_IN |=> (!PARALLEL_DATA_BUS_OE_OUT && WORD_READY_N_OUT))
    else $error("parallel pins active in serial mode");

  // parallel mode keeps the serial valid flag low
  a_serial_valid: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R02]
    PARALLEL_SEL_IN |=> !SERIAL_DATA_VALID_OUT)
    else $error("serial valid high in parallel mode");

  // settled flag held against an independent edge counter
  a_serial_data_valid_settle: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R16]
    serial_data_valid_q == (since_q > (SETTLE_W+1)'(SETTLE_CYCLES)))
    else $error("data valid not exactly settle time after release");

  // every fall of word ready sits on a convolution boundary
  a_first_word: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R17]
    $fell(WORD_READY_N_OUT) |-> (serial_data_valid_q && phase_q == PH_W'(1)))
    else $error("word ready fell off the convolution boundary");

  // each update loads the word presented at that edge
  a_word_load: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R17]
    upd |=> PARALLEL_DATA_BUS_OUT == $past(RAW_WORD_IN))
    else $error("output word not loaded at update");

  // unread word: two high cycles, then the next update
  a_ready_pulse: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R20]
    (PARALLEL_SEL_IN && serial_data_valid_q && phase_q == PHASE_PULSE) ##1 PARALLEL_SEL_IN[*2]
    |-> ##0 (WORD_READY_N_OUT && $past(WORD_READY_N_OUT)) ##1 !WORD_READY_N_OUT)
    else $error("word ready pulse before update wrong");

  // a finished read lifts word ready unless an update lands on the same edge
  a_read_done: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R19]
    (rd_done && !upd && PARALLEL_SEL_IN) |=> WORD_READY_N_OUT)
    else $error("word ready not raised after read");

  // first edge after release starts the sequencer from zero
  a_sync_zero: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R13]
    since_q == (SETTLE_W+1)'(1) |-> (phase_q == PH_W'(1) && !SERIAL_DATA_VALID_OUT))
    else $error("sequencer not restarted from zero");

  // held sync or reset keeps the sequencer at zero and word ready high
  a_sync_hold: assert property (@(posedge CLK_IN) // [R21]
    filt_rst ##1 filt_rst |-> (phase_q == PHASE_ZERO && WORD_READY_N_OUT))
    else $error("sequencer moved while sync or reset held");

  // sync or reset drops the serial valid flag at once
  a_valid_drop: assert property (@(posedge CLK_IN) // [R14]
    filt_rst ##1 filt_rst |-> !SERIAL_DATA_VALID_OUT)
    else $error("serial valid high during sync or reset");

  // release leaves word ready high and data not yet valid
  a_release_ready: assert property (@(posedge CLK_IN) disable iff (filt_rst) // [R15]
    $fell(filt_rst) |-> WORD_READY_N_OUT ##1 (WORD_READY_N_OUT && !SERIAL_DATA_VALID_OUT))
    else $error("word ready not high after release");

  // a one-cycle start runs both phases to the calibrated state
  a_cal_run: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // [R03]
    (CAL_START_IN && cal_state_q == adcsc_pkg::CAL_IDLE)
    |=> CAL_BUSY_OUT ##[1:CAL_MAX] CALIBRATED_OUT)
    else $error("calibration did not complete in time");

  // held reset keeps the stored values cleared
  a_cal_clear: assert property (@(posedge CLK_IN) // [R04]
    SYS_RST_IN ##1 SYS_RST_IN |-> (!CALIBRATED_OUT && CAL_OFFSET_OUT == adcsc_pkg::WORD_RST
      && CAL_GAIN_OUT == adcsc_pkg::WORD_RST))
    else $error("calibration values not cleared by reset");

  // only reset can return the block to the uncalibrated state
  a_cal_keep: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // [R04]
    CALIBRATED_OUT |=> CALIBRATED_OUT)
    else $error("calibrated state lost without reset");

  // held reset keeps the integrators shorted
  a_mod_hold: assert property (@(posedge CLK_IN) // [R06]
    SYS_RST_IN ##1 SYS_RST_IN |-> MOD_DISCHARGE_OUT)
    else $error("modulator discharge dropped during reset");

  // discharge ends at the first edge after release
  a_mod_clear: assert property (@(posedge CLK_IN) // [R06]
    $fell(SYS_RST_IN) |-> MOD_DISCHARGE_OUT ##1 !MOD_DISCHARGE_OUT)
    else $error("modulator discharge not released at first edge");

  c_read: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN) rd_done);
  c_cal: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN) $rose(CALIBRATED_OUT));
  c_serial_data_valid: cover property (@(posedge CLK_IN) disable iff (filt_rst) $rose(SERIAL_DATA_VALID_OUT));
  c_pulse: cover property (@(posedge CLK_IN) disable iff (filt_rst)
    $rose(WORD_READY_N_OUT) ##2 $fell(WORD_READY_N_OUT));
  c_release: cover property (@(posedge CLK_IN) $fell(filt_rst));

endmodule : adcsc_ctrl

`default_nettype wire

// ===== shared/adcsc_pkg.sv
// constants and types shared by the converter control and readout block
// assumes a single master clock; reset and filter sync arrive as async levels
// Summary of operation
// R01: all logic runs from one master clock
// R02: interface select high parallel, low serial
// R03: one-cycle calibrate pulse starts gain/offset calibration
// R04: reset clears stored offset and gain values
// R05: reset acts asynchronously, without the clock
// R06: reset rising edge discharges modulator integrators
// R07: reset also does everything filter sync does
// R08: chip select sampled as level on clock edge
// R09: bus driven when chip select and read low
// R10: chip select high floats all sixteen bus bits
// R11: serial mode host holds chip select low
// R12: filter sync accepted asynchronously
// R13: filter sync rising edge zeroes sequencer counter
// R14: serial data valid low on sync or reset
// R15: release at first edge sampling low; ready high
// R16: data valid high 8192 cycles after release
// R17: word ready low 64 cycles after that
// R18: read strobe sampled as level on clock edge
// R19: ready falls per word, rises after read
// R20: unread word: ready pulses high two cycles
// R21: sync or reset held keeps sequencer zero
package adcsc_pkg;

  // clock figures: nominal converter master clock and the clock this block sees
  localparam int MCLK_NOM_KHZ = 12500;
  localparam int CLK_MHZ = 250;
  localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;

  // output word and filter timing, in master clock cycles
  localparam int WORD_WIDTH = 16;
  localparam int CONV_CYCLES = 64;
  localparam int SETTLE_CYCLES = 8192;
  localparam int READY_HIGH_CYCLES = 2;

  // length of each calibration phase, in master clock cycles
  localparam int CAL_PHASE_CYCLES = 256;

  // reset values
  localparam logic [WORD_WIDTH-1:0] WORD_RST = 16'h0000;

  // calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_OFFSET = 2'b01,
    CAL_GAIN = 2'b10
  } adcsc_cal_type;

endpackage : adcsc_pkg

// ===== dv/adcsc_host.sv
// host reader model: reads one word after each fall of word_ready_n
// assumes the bench feeds it the resolved bus wire and the master clock
`timescale 1ns/100ps
`default_nettype none
module adcsc_host (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic serial_in,
  input wire logic [3:0] hold_in,
  input wire logic word_ready_n_in,
  input wire logic [15:0] bus_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic [15:0] word_out
);
  logic cs_q = 1'b1;
  logic rd_q = 1'b1;
  // serial mode keeps select low for good
  assign cs_n_out = serial_in ? 1'b0 : cs_q;
  assign rd_n_out = rd_q;
  // strobes held through the answer edge plus any extra hold, then released
  always begin
    @(negedge clk_in);
    if (en_in && !serial_in && word_ready_n_in === 1'b0) begin
      cs_q = 1'b0;
      rd_q = 1'b0;
      repeat (2 + hold_in) @(posedge clk_in);
      word_out = bus_in;
      @(negedge clk_in);
      cs_q = 1'b1;
      rd_q = 1'b1;
    end
  end
endmodule : adcsc_host
`default_nettype wire

// ===== dv/adcsc_ctrl_bench.sv
// self-checking bench for the converter control and readout block
// assumes adcsc_host as the reader; long counts are shortened by parameters
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module adcsc_ctrl_bench;
  localparam int SETTLE = 256;
  localparam int CONV = 8;
  localparam int CALP = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic cal = 1'b0;
  logic sync = 1'b0;
  logic host_en = 1'b0;
  logic [3:0] hold = 4'h0;
  logic [15:0] raw = 16'h0000;
  logic [15:0] off = 16'h0000;
  logic [15:0] gain = 16'h0000;
  logic cs_n, rd_n, oe, wrn, val, dis, busy, done;
  logic [15:0] dout, bus, hword, coff, cgain;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  // resolved bus: floats whenever the device lets go
  assign bus = oe ? dout : 16'hzzzz;
  always #2 clk = ~clk;
  adcsc_ctrl #(.SETTLE_CYCLES(SETTLE), .CONV_CYCLES(CONV), .CAL_PHASE_CYCLES(CALP))
  adcsc_ctrl_i (.CLK_IN(clk), .SYS_RST_IN(rst), .PARALLEL_SEL_IN(psel), .CAL_START_IN(cal),
    .FILTER_SYNC_IN(sync), .CHIP_SELECT_N_IN(cs_n), .READ_STROBE_N_IN(rd_n), .RAW_WORD_IN(raw),
    .CAL_OFFSET_IN(off), .CAL_GAIN_IN(gain), .PARALLEL_DATA_BUS_OUT(dout),
    .PARALLEL_DATA_BUS_OE_OUT(oe), .WORD_READY_N_OUT(wrn), .SERIAL_DATA_VALID_OUT(val),
    .MOD_DISCHARGE_OUT(dis), .CAL_BUSY_OUT(busy), .CALIBRATED_OUT(done),
    .CAL_OFFSET_OUT(coff), .CAL_GAIN_OUT(cgain));
  adcsc_host adcsc_host_i (.clk_in(clk), .en_in(host_en), .serial_in(~psel), .hold_in(hold),
    .word_ready_n_in(wrn), .bus_in(bus), .cs_n_out(cs_n), .rd_n_out(rd_n), .word_out(hword));
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // bounded wait for word ready (on_oe low) or the bus enable, just after each edge;
  // a wait that runs out counts as a mismatch
  task automatic await(input bit on_oe, input logic v);
    int k;
    k = 0;
    while (k < 100 && (on_oe ? oe : wrn) !== v) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 100) begin
      fail_count++;
      $display("unexpected at %0t: wait ran out, got %h expected %h", $time, on_oe ? oe : wrn, v);
    end
  endtask : await
  // hold sync or reset five cycles, release, count edges to the first answer
  task automatic settle(input logic by_rst, output int cnt);
    @(negedge clk);
    if (by_rst) begin
      rst = 1'b1;
    end else begin
      sync = 1'b1;
    end
    repeat (5) @(negedge clk);
    `CHK(val, 1'b0)
    `CHK(wrn, 1'b1)
    rst = 1'b0;
    sync = 1'b0;
    @(posedge clk);
    #1;
    `CHK(wrn, 1'b1)
    cnt = 0;
    while (cnt < 2000 && (psel ? wrn !== 1'b0 : val !== 1'b1)) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask : settle
  initial begin
    repeat (10) @(negedge clk);
    `CHK(dis, 1'b1)
    `CHK(done, 1'b0)
    rst = 1'b0;
    @(posedge clk);
    #1;
    `CHK(dis, 1'b0)
    // one-cycle start; offset kept after the first phase, gain and the calibrated flag after the second
    @(negedge clk);
    off = 16'h1234;
    gain = 16'h4321;
    cal = 1'b1;
    @(negedge clk);
    cal = 1'b0;
    repeat (2 * CALP - 1) @(posedge clk);
    #1;
    `CHK(busy, 1'b1)
    `CHK(done, 1'b0)
    @(posedge clk);
    #1;
    `CHK(done, 1'b1)
    `CHK(coff, 16'h1234)
    `CHK(cgain, 16'h4321)
    @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
    // reset between edges must act with no clock edge at all
    @(negedge clk);
    rst = 1'b1;
    #1;
    `CHK(done, 1'b0)
    `CHK(coff, 16'h0000)
    `CHK(dis, 1'b1)
    settle(1'b1, n);
    `CHK(n, SETTLE)
    `CHK(wrn, 1'b1)
    settle(1'b0, n);
    `CHK(n, SETTLE)
    // parallel mode with nobody reading
    @(negedge clk);
    psel = 1'b1;
    raw = 16'ha5c3;
    settle(1'b0, n);
    `CHK(n, SETTLE + CONV)
    `CHK(val, 1'b0)
    `CHK(oe, 1'b0)
    n = 0;
    while (n < 100 && wrn !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, CONV - 2)
    n = 0;
    while (n < 100 && wrn !== 1'b0) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, 2)
    // prompt read, then a slow one; each must lift word_ready_n when done
    for (int h = 0; h < 4; h += 3) begin
      @(negedge clk);
      raw = {12'h5a3, 4'(h)};
      hold = 4'(h);
      await(1'b0, 1'b1);
      await(1'b0, 1'b0);
      host_en = 1'b1;
      await(1'b1, 1'b1);
      `CHK(bus, raw)
      await(1'b1, 1'b0);
      host_en = 1'b0;
      `CHK(wrn, 1'b1)
      `CHK(hword, raw)
    end
    give_verdict();
  end
  // the whole sequence needs about 900 cycles; this span is ample
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule : adcsc_ctrl_bench
`default_nettype wire
